// ===== src/prog_map.vh
`ifndef PROG_MAP_VH
`define PROG_MAP_VH

// ********************************************************************
// Clock and programming times, each in nanoseconds.
// ********************************************************************

// Clock period of the controller.
`define T_CLK_NS            10
// Nominal program pulse width on the device select pin.
`define T_PULSE_NS          50000
// Least setup and hold time around every programming step.
`define T_SETUP_NS          2000
// Longest delay from select low to valid read data.
`define T_DATA_VALID_NS     1000

// ********************************************************************
// Counts, widths and reset values.
// ********************************************************************

// Extra pulses allowed for a byte that fails verification.
`define MAX_RETRY           10
// Address width of the memory array.
`define ADDR_W              20
// Highest address of the memory array.
`define LAST_ADDR           20'hfffff
// Data width of the memory.
`define DATA_W              8
// Reset value of the address pins.
`define ADDR_RESET          20'h00000
// Reset value of the data pins.
`define DATA_RESET          8'h00

`endif

// ===== src/eprom_programmer.v
// Operation
// - Program pulse is select low, fifty microseconds.
// - Programming run starts at the first address.
// - Raise supply and gate voltage before pulsing.
// - First pass: one pulse per address, no verify.
// - Then verify every address against intended data.
// - Mismatch: up to ten pulses, verify after each.
// - Still failing after ten pulses: part failed.
// - Verified byte: step on until all checked.
// - Lower gate and supply, re-read and compare all (the final read-back here stops at the first mismatch).
// - Identification needs tenth address line at high voltage.
`timescale 1ns/100ps
`include "prog_map.vh"

module eprom_programmer
#(
  parameter ADDR_W     = `ADDR_W,
  parameter DATA_W     = `DATA_W,
  parameter LAST_ADDR  = `LAST_ADDR,
  parameter MAX_RETRY  = `MAX_RETRY,
  parameter PULSE_CYC  = (`T_PULSE_NS + `T_CLK_NS - 1) / `T_CLK_NS
)
(
  input  wire              clk,
  input  wire              rstn,
  input  wire              start,
  input  wire              id_start,
  output reg  [ADDR_W-1:0] addr,
  output reg  [DATA_W-1:0] dq_out,
  output reg               dq_oe,
  input  wire [DATA_W-1:0] dq_in,
  output reg               select_n,
  output reg               gate_n,
  output reg               vpp_en,
  output reg               vcc_prog,
  output reg               id_voltage_en,
  output wire              src_req,
  input  wire              src_valid,
  input  wire [DATA_W-1:0] src_data,
  output wire              rd_valid,
  input  wire              rd_ready,
  output wire [DATA_W-1:0] rd_data,
  output wire              busy,
  output reg               done,
  output reg               pass
);

  // ******************************************************************
  // Timing counts and encodings.
  // ******************************************************************

  // Least times round up to whole clock cycles.
  function integer cycles_up;
    input integer ns;
    begin
      cycles_up = (ns + `T_CLK_NS - 1) / `T_CLK_NS;
    end
  endfunction

  localparam integer SETUP_CYC = cycles_up(`T_SETUP_NS);
  localparam integer DV_CYC    = cycles_up(`T_DATA_VALID_NS);

  // Controller states.
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_VCC    = 4'h1;
  localparam [3:0] S_VPP    = 4'h2;
  localparam [3:0] S_FETCH  = 4'h3;
  localparam [3:0] S_LOAD   = 4'h4;
  localparam [3:0] S_PULSE  = 4'h5;
  localparam [3:0] S_HOLD   = 4'h6;
  localparam [3:0] S_READ   = 4'h7;
  localparam [3:0] S_CHECK  = 4'h8;
  localparam [3:0] S_FINISH = 4'h9;

  // Phases of a run.
  localparam [1:0] P_FIRST  = 2'h0;
  localparam [1:0] P_VERIFY = 2'h1;
  localparam [1:0] P_FINAL  = 2'h2;
  localparam [1:0] P_ID     = 2'h3;

  // ******************************************************************
  // State.
  // ******************************************************************

  reg  [3:0]        state;     // Current controller state.
  reg  [1:0]        phase;     // Which pass of the run is active.
  reg  [23:0]       timer;     // Cycles left in the current wait.
  reg  [3:0]        retry;     // Extra pulses given to this byte.
  reg  [DATA_W-1:0] want;      // Intended data of this address.
  reg  [DATA_W-1:0] got;       // Byte read back from the device.
  reg               result_ok; // Outcome carried into the finish state.

  wire timer_done = (timer == 24'h000000);
  wire last_addr  = (addr == LAST_ADDR[ADDR_W-1:0]);
  wire match      = (got == want);

  // Read bytes of the final pass and identification go to the buffer.
  wire push_valid = (state == S_CHECK) && ((phase == P_FINAL) || (phase == P_ID));
  wire push_ready;

  // The source is asked for the byte at the address now on the pins.
  assign src_req = (state == S_FETCH);
  assign busy    = (state != S_IDLE);

  // ******************************************************************
  // Main sequencer.
  // ******************************************************************

  // One process steps through the passes; every pin it drives is a flop,
  // so the device never sees a glitch from decode logic.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state         <= S_IDLE;
      phase         <= P_FIRST;
      timer         <= 24'h000000;
      retry         <= 4'h0;
      want          <= `DATA_RESET;
      got           <= `DATA_RESET;
      result_ok     <= 1'b0;
      addr          <= `ADDR_RESET;
      dq_out        <= `DATA_RESET;
      dq_oe         <= 1'b0;
      select_n      <= 1'b1;
      gate_n        <= 1'b1;
      vpp_en        <= 1'b0;
      vcc_prog      <= 1'b0;
      id_voltage_en <= 1'b0;
      done          <= 1'b0;
      pass          <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!timer_done)
      begin
        // Waits are counted down before any state acts.
        timer <= timer - 24'h000001;
      end
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            // A run always begins at the first location.
            addr     <= `ADDR_RESET;
            phase    <= P_FIRST;
            retry    <= 4'h0;
            vcc_prog <= 1'b1;
            timer    <= SETUP_CYC[23:0] - 24'h000001;
            state    <= S_VCC;
          end
          else if (id_start)
          begin
            // Identification is a read at normal supply with the identification voltage raised.
            addr          <= `ADDR_RESET;
            phase         <= P_ID;
            id_voltage_en <= 1'b1;
            timer         <= SETUP_CYC[23:0] - 24'h000001;
            state         <= S_VCC;
          end
        end
        S_VCC:
        begin
          if (timer_done)
          begin
            if (phase == P_FIRST)
            begin
              // Supply is up; now the gate pin goes to programming voltage.
              vpp_en <= 1'b1;
              timer  <= SETUP_CYC[23:0] - 24'h000001;
              state  <= S_VPP;
            end
            else if (phase == P_ID)
            begin
              // Lowest address bit low selects the maker code first.
              gate_n   <= 1'b0;
              select_n <= 1'b0;
              timer    <= DV_CYC[23:0] - 24'h000001;
              state    <= S_READ;
            end
            else
            begin
              state <= S_FETCH;
            end
          end
        end
        S_VPP:
        begin
          if (timer_done)
          begin
            state <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          if (src_valid)
          begin
            want <= src_data;
            if (phase == P_FIRST)
            begin
              // First pass drives the byte and pulses without reading.
              dq_out <= src_data;
              dq_oe  <= 1'b1;
              timer  <= SETUP_CYC[23:0] - 24'h000001;
              state  <= S_LOAD;
            end
            else
            begin
              // Verify and final reads drop the gate pin to a logic low.
              vpp_en   <= 1'b0;
              gate_n   <= 1'b0;
              select_n <= 1'b0;
              timer    <= DV_CYC[23:0] - 24'h000001;
              state    <= S_READ;
            end
          end
        end
        S_LOAD:
        begin
          if (timer_done)
          begin
            // Pulse width is the nominal count, well inside the tolerance.
            select_n <= 1'b0;
            timer    <= PULSE_CYC[23:0] - 24'h000001;
            state    <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          if (timer_done)
          begin
            select_n <= 1'b1;
            timer    <= SETUP_CYC[23:0] - 24'h000001;
            state    <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          if (timer_done)
          begin
            dq_oe <= 1'b0;
            if (phase == P_FIRST)
            begin
              if (last_addr)
              begin
                // Every address has had its single pulse.
                phase <= P_VERIFY;
                addr  <= `ADDR_RESET;
              end
              else
              begin
                addr <= addr + 1'b1;
              end
              state <= S_FETCH;
            end
            else
            begin
              // A retry pulse is always followed by its own verify read.
              vpp_en   <= 1'b0;
              gate_n   <= 1'b0;
              select_n <= 1'b0;
              timer    <= DV_CYC[23:0] - 24'h000001;
              state    <= S_READ;
            end
          end
        end
        S_READ:
        begin
          if (timer_done)
          begin
            got      <= dq_in;
            select_n <= 1'b1;
            gate_n   <= 1'b1;
            state    <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          if (phase == P_VERIFY)
          begin
            if (match)
            begin
              retry <= 4'h0;
              if (last_addr)
              begin
                // Leave programming levels, then re-read the part from the first address until a mismatch or the last address.
                vcc_prog <= 1'b0;
                phase    <= P_FINAL;
                addr     <= `ADDR_RESET;
                timer    <= SETUP_CYC[23:0] - 24'h000001;
                state    <= S_VCC;
              end
              else
              begin
                addr  <= addr + 1'b1;
                state <= S_FETCH;
              end
            end
            else if (retry == MAX_RETRY[3:0])
            begin
              // Byte is beyond repair; the whole part is failed.
              result_ok <= 1'b0;
              state     <= S_FINISH;
            end
            else
            begin
              retry  <= retry + 4'h1;
              vpp_en <= 1'b1;
              dq_out <= want;
              dq_oe  <= 1'b1;
              timer  <= SETUP_CYC[23:0] - 24'h000001;
              state  <= S_LOAD;
            end
          end
          else if (push_ready)
          begin
            // The buffer took the byte; a full buffer simply holds us here.
            if (phase == P_ID)
            begin
              if (!addr[0])
              begin
                addr[0]  <= 1'b1;
                gate_n   <= 1'b0;
                select_n <= 1'b0;
                timer    <= DV_CYC[23:0] - 24'h000001;
                state    <= S_READ;
              end
              else
              begin
                result_ok <= 1'b1;
                state     <= S_FINISH;
              end
            end
            else if (!match)
            begin
              result_ok <= 1'b0;
              state     <= S_FINISH;
            end
            else if (last_addr)
            begin
              result_ok <= 1'b1;
              state     <= S_FINISH;
            end
            else
            begin
              addr  <= addr + 1'b1;
              state <= S_FETCH;
            end
          end
        end
        S_FINISH:
        begin
          // Gate pin is already at a logic level from the last read; the supply, if still raised, drops after it.
          vpp_en        <= 1'b0;
          vcc_prog      <= 1'b0;
          id_voltage_en <= 1'b0;
          dq_oe         <= 1'b0;
          select_n      <= 1'b1;
          gate_n        <= 1'b1;
          pass          <= result_ok;
          done          <= 1'b1;
          state         <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Two-entry read-back buffer.
  // ******************************************************************

  // Two entries let the receiver stall for a cycle without the sequencer
  // having to hold the device pins any longer than one read.
  reg [DATA_W-1:0] buf_mem [0:1]; // Stored bytes.
  reg              wr_ptr;        // Next entry to write.
  reg              rd_ptr;        // Next entry to read.
  reg [1:0]        count;         // Entries held, zero to two.

  assign push_ready = (count != 2'h2);
  assign rd_valid   = (count != 2'h0);
  assign rd_data    = buf_mem[rd_ptr];

  wire do_push = push_valid && push_ready;
  wire do_pop  = rd_valid && rd_ready;

  // Pointers and occupancy; a push and a pop in one cycle keep the count.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
      buf_mem[0] <= `DATA_RESET;
      buf_mem[1] <= `DATA_RESET;
    end
    else
    begin
      if (do_push)
      begin
        buf_mem[wr_ptr] <= got;
        wr_ptr          <= ~wr_ptr;
      end
      if (do_pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 2'h1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 2'h1;
      end
    end
  end

endmodule

// ===== verif/prog_check_sva.sv
`timescale 1ns/100ps
module prog_check
#(
  parameter ADDR_W    = 20,
  parameter DATA_W    = 8,
  parameter PULSE_CYC = 5000
)
(
  input wire              clk,
  input wire              rstn,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] dq_out,
  input wire              dq_oe,
  input wire              select_n,
  input wire              gate_n,
  input wire              vpp_en,
  input wire              vcc_prog,
  input wire              id_voltage_en,
  input wire              src_req,
  input wire              src_valid,
  input wire              rd_valid,
  input wire              rd_ready,
  input wire [DATA_W-1:0] rd_data,
  input wire              busy,
  input wire              done
);
  // Cycles that the select pin has been low so far.
  integer lo_cnt;
  // Program pulses given since the last source request.
  integer pcnt;
  // High from the start of a run until its first source request.
  reg     first;

  // ********************************************************************
  // Helper counters.
  // ********************************************************************
  // A counter is cheaper for the tools than a long repetition.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lo_cnt <= 0;
      pcnt <= 0;
      first <= 1'b0;
    end
    else
    begin
      lo_cnt <= select_n ? 0 : lo_cnt + 1;
      pcnt <= src_req ? 0 : pcnt + ((!select_n && vpp_en && lo_cnt == 0) ? 1 : 0);
      first <= src_req ? 1'b0 : (first | $rose(busy));
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pulse_width: assert property ($rose(select_n) && vpp_en |-> lo_cnt == PULSE_CYC)
    else $error("program pulse has the wrong length");
  a_first_address: assert property (first && src_req |-> addr == 0)
    else $error("run does not begin at the first address");
  a_supply_first: assert property ($rose(vpp_en) |-> vcc_prog && $past(vcc_prog, 150))
    else $error("gate voltage raised before the supply");
  a_pulse_steady: assert property (!select_n && vpp_en |->
    vcc_prog && dq_oe && $stable(dq_out) && $stable(addr))
    else $error("data or address moved during a pulse");
  a_read_float: assert property (!gate_n && !vpp_en |-> !dq_oe)
    else $error("controller drives data during a read");
  a_retry_bound: assert property (pcnt <= 10)
    else $error("too many pulses on one byte");
  a_src_hold: assert property (src_req && !src_valid |=> src_req && $stable(addr))
    else $error("source request dropped or moved");
  a_final_normal: assert property ($rose(rd_valid) |-> !vcc_prog && !vpp_en)
    else $error("read-back made at programming levels");
  a_id_level: assert property (id_voltage_en |-> !vpp_en && !vcc_prog)
    else $error("identification read at programming levels");
  a_done_pulse: assert property (done |=> !done && !busy)
    else $error("done is not a single idle pulse");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read-back word lost under stall");
endmodule

bind eprom_programmer prog_check #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PULSE_CYC(PULSE_CYC)) u_prog_check (
  .clk(clk), .rstn(rstn), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .select_n(select_n),
  .gate_n(gate_n), .vpp_en(vpp_en), .vcc_prog(vcc_prog), .id_voltage_en(id_voltage_en),
  .src_req(src_req), .src_valid(src_valid), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .rd_data(rd_data), .busy(busy), .done(done));

// ===== verif/eprom_model.sv
`timescale 1ns/100ps
module eprom_model
#(
  parameter MAKER_CODE = 8'h5c, // Arbitrary value.
  parameter TYPE_CODE  = 8'ha3  // Arbitrary value.
)
(
  input  wire [19:0] addr,
  input  wire [7:0]  dq_out,
  input  wire        dq_oe,
  input  wire        select_n,
  input  wire        gate_n,
  input  wire        vpp_en,
  input  wire        vcc_prog,
  input  wire        id_voltage_en,
  output wire [7:0]  dq_in
);
  // Array contents, pulses needed in total and pulses taken, per byte.
  reg     [7:0] mem [0:3];
  integer       need [0:3];
  integer       hits [0:3];
  // Byte that loses a bit when the supply drops, or -1.
  integer       leak;
  wire          rd_en = !select_n && !gate_n && !vpp_en;
  wire          rd_late;
  // Data is slow to appear, so an early sample sees the wrong byte.
  assign #500 rd_late = rd_en;
  wire    [7:0] val = id_voltage_en ? (addr[0] ? TYPE_CODE : MAKER_CODE) : mem[addr[1:0]];
  // Released lines show the inverse, never a stale copy.
  assign dq_in = dq_oe ? dq_out : ((rd_en && rd_late) ? val : ~val);

  // A weak byte only takes its data after enough pulses.
  always @(posedge select_n)
  begin
    if (vpp_en && vcc_prog && dq_oe)
    begin
      hits[addr[1:0]] = hits[addr[1:0]] + 1;
      if (hits[addr[1:0]] >= need[addr[1:0]])
        mem[addr[1:0]] = mem[addr[1:0]] & dq_out;
    end
  end

  // A leaky cell shows up only in the final read-back.
  always @(negedge vcc_prog)
    if (leak >= 0)
      mem[leak] = mem[leak] ^ 8'h01;
endmodule

// ===== verif/eprom_programmer_bench.sv
`timescale 1ns/100ps
module eprom_programmer_bench;
  localparam MAKER = 8'h5c; // Arbitrary value.
  localparam KIND  = 8'ha3; // Arbitrary value.
  reg         clk, rstn, start, id_start, src_valid, rd_ready;
  reg  [7:0]  src_data;
  wire [19:0] addr;
  wire [7:0]  dq_out, dq_in, rd_data;
  wire        dq_oe, select_n, gate_n, vpp_en, vcc_prog, id_voltage_en;
  wire        src_req, rd_valid, busy, done, pass;
  reg  [7:0]  src_mem [0:3];
  reg  [7:0]  got [$];
  integer     mismatches, checks_done, gap, s, i;
  // Cycles left in a forced read-back stall, and whether one is armed.
  integer     stall_left;
  reg         stall_arm;

  eprom_programmer #(.LAST_ADDR(20'h3), .PULSE_CYC(20)) u_eprom_programmer (
    .clk(clk), .rstn(rstn), .start(start), .id_start(id_start), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .select_n(select_n), .gate_n(gate_n), .vpp_en(vpp_en),
    .vcc_prog(vcc_prog), .id_voltage_en(id_voltage_en), .src_req(src_req), .src_valid(src_valid),
    .src_data(src_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .busy(busy), .done(done), .pass(pass));

  eprom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(KIND)) u_eprom_model (
    .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .select_n(select_n), .gate_n(gate_n),
    .vpp_en(vpp_en), .vcc_prog(vcc_prog), .id_voltage_en(id_voltage_en), .dq_in(dq_in));

  always #5 clk = ~clk;

  // ********************************************************************
  // Source and read-back drivers.
  // ********************************************************************
  // The source answers after a random gap; stray valids must be ignored.
  always @(posedge clk)
  begin
    #1;
    // A long stall after the first read-back word fills the buffer, so the
    // sequencer must wait in its check state without losing a byte.
    if (stall_arm && rd_valid === 1'b1)
    begin
      stall_arm = 1'b0;
      stall_left = 300;
    end
    rd_ready = (stall_left == 0) && (($urandom % 3) != 0);
    if (stall_left > 0)
      stall_left = stall_left - 1;
    if (src_req === 1'b1 && gap == 0)
    begin
      src_valid = 1'b1;
      src_data = src_mem[addr[1:0]];
      gap = $urandom % 4;
    end
    else
    begin
      src_valid = (src_req !== 1'b1) && ($urandom % 8 == 0);
      src_data = $urandom;
      if (src_req === 1'b1)
        gap = gap - 1;
    end
  end

  // Words are taken at the next rising edge, so collect them here.
  always @(negedge clk)
    if (rd_valid === 1'b1 && rd_ready)
      got.push_back(rd_data);

  // Expected read-back byte, with the leaky byte's bit turned.
  function [7:0] exp_byte(input integer n, input integer bad);
    exp_byte = (n == bad) ? src_mem[n] ^ 8'h01 : src_mem[n];
  endfunction

  task check(input string what, input [7:0] exp, input [7:0] act);
    begin
      checks_done = checks_done + 1;
      if (act !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", what, exp, act);
      end
    end
  endtask

  task close_out;
    begin
      if (mismatches == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // One run; a second start while busy must change nothing.
  task run(input reg id, input reg ok, input integer cnt, input integer bad);
    integer n;
    begin
      got.delete();
      @(posedge clk);
      #1;
      start = !id;
      id_start = id;
      @(posedge clk);
      #1;
      id_start = 1'b0;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 60000)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n == 60000)
      begin
        mismatches = mismatches + 1;
        close_out;
      end
      check("pass", {7'h0, ok}, {7'h0, pass});
      n = 0;
      while (rd_valid === 1'b1 && n < 50)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      n = got.size();
      check("count", cnt[7:0], n[7:0]);
      for (n = 0; n < cnt; n = n + 1)
        check("byte", id ? (n ? KIND : MAKER) : exp_byte(n, bad), got[n]);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    start = 1'b0;
    id_start = 1'b0;
    src_valid = 1'b0;
    rd_ready = 1'b0;
    src_data = 8'h00;
    gap = 0;
    stall_left = 0;
    stall_arm = 1'b0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(32'h369a6bf8));
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    check("select", 8'h01, {7'h0, select_n});
    check("busy", 8'h00, {7'h0, busy});
    // Plain run, eleven pulses at the limit, twelve beyond it, leaky byte.
    for (s = 0; s < 4; s = s + 1)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        // An erased byte always reads all ones, so a target of all ones
        // would verify without a pulse and hide the retry corner cases.
        src_mem[i] = $urandom % 255;
        u_eprom_model.mem[i] = 8'hff;
        u_eprom_model.hits[i] = 0;
        u_eprom_model.need[i] = 1 + $urandom % 3;
      end
      u_eprom_model.leak = (s == 3) ? 2 : -1;
      stall_arm = (s == 0);
      if (s == 1)
        u_eprom_model.need[1] = 11;
      if (s == 2)
        u_eprom_model.need[2] = 12;
      run(1'b0, s < 2, (s == 2) ? 0 : ((s == 3) ? 3 : 4), u_eprom_model.leak);
    end
    run(1'b1, 1'b1, 2, -1);
    close_out;
  end
endmodule
